// >>> design/cimb_top.sv
// charger interrupt mask bank: serial register slave, mask gating, recharge flag, input limit select
// Notes on behaviour
// - mask bit 0 lets its event drive the interrupt, 1 blocks it.
// - missing-battery mask bit blocks missing-battery events from the interrupt.
// - charger fault mask bit 7 gates the input-reverse protection fault.
// - charger fault mask bit 1 gates the thermal regulation loop warning.
// - boost fault mask bit 6 gates the boost overload fault.
// - boost fault mask bit 5 gates boost low battery; bits 4..0 reserved.
// - recharge flag sets when battery below regulation minus threshold; recharge mask gates it.
`timescale 1ns/1ps
`default_nettype none
module cimb_top #(
    parameter logic [6:0] SLAVE_ADDR = cimb_pkg::DEFAULT_SLAVE_ADDR
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // serial register bus pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // fault flags and charger status
    input wire cimb_pkg::cimb_flags_t FLAGS,
    input wire cimb_pkg::cimb_volt_t VOLTS,
    input wire logic RECHARGE_CLEAR,
    input wire logic [2:0] DETECTED_KIND,
    input wire logic DETECTION_RUNNING,
    input wire logic [4:0] KIND_LIMIT,
    input wire logic [4:0] AVERAGE_LIMIT,
    // interrupt and control outputs
    output logic IRQ_OUT,
    output logic IRQ_OE_N,
    output logic RECHARGE_FLAG,
    output logic [4:0] INPUT_LIMIT,
    output logic SECONDARY_DETECT_EN,
    output logic PRIMARY_DETECT_EN
);
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic next_scl_s1, next_scl_s2, next_scl_s3, next_sda_s1, next_sda_s2, next_sda_s3;
    cimb_pkg::cimb_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift, ptr, next_ptr, rd_data;
    logic rw, next_rw, nack, next_nack, oe_n, next_oe_n;
    logic wr_en;
    logic [7:0] wr_addr, wr_data;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] system_mask, next_system_mask, charger_mask, next_charger_mask;
    logic [7:0] boost_mask, next_boost_mask;
    logic [1:0] input_limit_source_select, next_input_limit_source_select;
    logic secondary_detect_enable, next_secondary_detect_enable;
    logic primary_detect_enable, next_primary_detect_enable;
    logic recharge_request_flag, next_recharge_flag, below;
    logic [10:0] threshold;
    logic [7:0] chg_eff;
    logic pending, next_irq_oe_n;
    logic [4:0] limit, next_limit;

    // pin synchronisers and edge history
    always_comb begin
        next_scl_s1 = SCL_IN;
        next_scl_s2 = scl_s1;
        next_scl_s3 = scl_s2;
        next_sda_s1 = SDA_IN;
        next_sda_s2 = sda_s1;
        next_sda_s3 = sda_s2;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= next_scl_s1;
            scl_s2 <= next_scl_s2;
            scl_s3 <= next_scl_s3;
            sda_s1 <= next_sda_s1;
            sda_s2 <= next_sda_s2;
            sda_s3 <= next_sda_s3;
        end
    end

    // bus conditions seen on synchronised pins
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_seen = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_seen = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

    // register read mux, unmapped offsets read zero
    always_comb begin
        unique case (ptr)
            cimb_pkg::SYS_FAULT_MASK_ADDR: rd_data = system_mask;
            cimb_pkg::CHARGER_FAULT_MASK_ADDR: rd_data = charger_mask;
            cimb_pkg::BOOST_FAULT_MASK_ADDR: rd_data = boost_mask & cimb_pkg::BOOST_MASK_USED;
            cimb_pkg::DETECT_CONTROL_ADDR: rd_data = {DETECTED_KIND, input_limit_source_select,
                secondary_detect_enable, primary_detect_enable, DETECTION_RUNNING};
            default: rd_data = cimb_pkg::UNMAPPED_READ;
        endcase
    end

    // serial slave: address, pointer, write bytes, read bytes with auto increment
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_rw = rw;
        next_nack = nack;
        next_oe_n = oe_n;
        wr_en = 1'b0;
        wr_addr = ptr;
        wr_data = shift;
        if (stop_seen) begin
            next_state = cimb_pkg::CIMB_IDLE;
            next_oe_n = 1'b1;
        end else if (start_seen) begin
            next_state = cimb_pkg::CIMB_ADDR;
            next_cnt = 4'h0;
            next_oe_n = 1'b1;
        end else begin
            unique case (state)
                cimb_pkg::CIMB_IDLE: begin
                    next_oe_n = 1'b1;
                end
                cimb_pkg::CIMB_ADDR, cimb_pkg::CIMB_REG, cimb_pkg::CIMB_WDATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s2};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == cimb_pkg::BITS_PER_BYTE) begin
                        next_oe_n = 1'b0; // acknowledge
                        if (state == cimb_pkg::CIMB_ADDR) begin
                            if (shift[7:1] == SLAVE_ADDR) begin
                                next_rw = shift[0];
                                next_state = cimb_pkg::CIMB_ACK_ADDR;
                            end else begin
                                next_oe_n = 1'b1;
                                next_state = cimb_pkg::CIMB_IDLE;
                            end
                        end else if (state == cimb_pkg::CIMB_REG) begin
                            next_ptr = shift;
                            next_state = cimb_pkg::CIMB_ACK_REG;
                        end else begin
                            wr_en = 1'b1;
                            next_ptr = ptr + 8'h01;
                            next_state = cimb_pkg::CIMB_ACK_W;
                        end
                    end
                end
                cimb_pkg::CIMB_ACK_ADDR, cimb_pkg::CIMB_ACK_REG, cimb_pkg::CIMB_ACK_W: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (state == cimb_pkg::CIMB_ACK_ADDR && rw) begin
                            next_shift = rd_data;
                            next_oe_n = rd_data[7];
                            next_state = cimb_pkg::CIMB_RDATA;
                        end else begin
                            next_oe_n = 1'b1;
                            next_state = (state == cimb_pkg::CIMB_ACK_ADDR) ? cimb_pkg::CIMB_REG
                                                                           : cimb_pkg::CIMB_WDATA;
                        end
                    end
                end
                cimb_pkg::CIMB_RDATA: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == cimb_pkg::BITS_PER_BYTE) begin
                            next_oe_n = 1'b1; // master acknowledges
                            next_ptr = ptr + 8'h01;
                            next_state = cimb_pkg::CIMB_ACK_R;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_oe_n = shift[6];
                        end
                    end
                end
                cimb_pkg::CIMB_ACK_R: begin
                    if (scl_rise) begin
                        next_nack = sda_s2;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (nack) begin
                            next_state = cimb_pkg::CIMB_IDLE;
                        end else begin
                            next_shift = rd_data;
                            next_oe_n = rd_data[7];
                            next_state = cimb_pkg::CIMB_RDATA;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= cimb_pkg::CIMB_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b1;
            oe_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            rw <= next_rw;
            nack <= next_nack;
            oe_n <= next_oe_n;
        end
    end

    // mask and detect control registers
    always_comb begin
        next_system_mask = system_mask;
        next_charger_mask = charger_mask;
        next_boost_mask = boost_mask;
        next_input_limit_source_select = input_limit_source_select;
        next_secondary_detect_enable = secondary_detect_enable;
        next_primary_detect_enable = primary_detect_enable;
        if (wr_en) begin
            unique case (wr_addr)
                cimb_pkg::SYS_FAULT_MASK_ADDR: next_system_mask = wr_data;
                cimb_pkg::CHARGER_FAULT_MASK_ADDR: next_charger_mask = wr_data;
                cimb_pkg::BOOST_FAULT_MASK_ADDR: next_boost_mask = wr_data & cimb_pkg::BOOST_MASK_USED;
                cimb_pkg::DETECT_CONTROL_ADDR: begin
                    next_input_limit_source_select = wr_data[cimb_pkg::SEL_LSB +: 2];
                    next_secondary_detect_enable = wr_data[cimb_pkg::SECONDARY_BIT];
                    next_primary_detect_enable = wr_data[cimb_pkg::PRIMARY_BIT];
                end
                default: next_system_mask = system_mask; // unmapped writes ignored
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            system_mask <= cimb_pkg::SYS_FAULT_MASK_RESET;
            charger_mask <= cimb_pkg::CHARGER_FAULT_MASK_RESET;
            boost_mask <= cimb_pkg::BOOST_FAULT_MASK_RESET;
            input_limit_source_select <= cimb_pkg::DETECT_CONTROL_RESET[cimb_pkg::SEL_LSB +: 2];
            secondary_detect_enable <= cimb_pkg::DETECT_CONTROL_RESET[cimb_pkg::SECONDARY_BIT];
            primary_detect_enable <= cimb_pkg::DETECT_CONTROL_RESET[cimb_pkg::PRIMARY_BIT];
        end else begin
            system_mask <= next_system_mask;
            charger_mask <= next_charger_mask;
            boost_mask <= next_boost_mask;
            input_limit_source_select <= next_input_limit_source_select;
            secondary_detect_enable <= next_secondary_detect_enable;
            primary_detect_enable <= next_primary_detect_enable;
        end
    end

    // recharge request: sticky, set beats clear
    assign threshold = {1'b0, VOLTS.reg_level} - {1'b0, VOLTS.recharge};
    assign below = ~threshold[10] && ({1'b0, VOLTS.bat} < threshold);
    assign next_recharge_flag = below | (recharge_request_flag & ~RECHARGE_CLEAR);

    // mask gating: a 0 mask bit lets the flag through
    always_comb begin
        chg_eff = FLAGS.chg;
        chg_eff[cimb_pkg::RECHARGE_REQUEST_BIT] = recharge_request_flag;
        pending = |(FLAGS.sys & ~system_mask)
                | |(chg_eff & ~charger_mask)
                | |(FLAGS.bst & ~boost_mask & cimb_pkg::BOOST_MASK_USED);
        next_irq_oe_n = ~pending;
    end

    // input current limit source
    always_comb begin
        unique case (input_limit_source_select)
            cimb_pkg::LIMIT_FROM_KIND: next_limit = KIND_LIMIT;
            cimb_pkg::LIMIT_FROM_AVERAGE: next_limit = AVERAGE_LIMIT;
            cimb_pkg::LIMIT_HIGHER: next_limit = (KIND_LIMIT > AVERAGE_LIMIT) ? KIND_LIMIT : AVERAGE_LIMIT;
            cimb_pkg::LIMIT_LOWER: next_limit = (KIND_LIMIT < AVERAGE_LIMIT) ? KIND_LIMIT : AVERAGE_LIMIT;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            recharge_request_flag <= 1'b0;
            IRQ_OE_N <= 1'b1;
            limit <= 5'h00;
        end else begin
            recharge_request_flag <= next_recharge_flag;
            IRQ_OE_N <= next_irq_oe_n;
            limit <= next_limit;
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SDA_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0; // open drain, only ever pulls low
            IRQ_OUT <= 1'b0;
        end
    end

    assign SDA_OE_N = oe_n;
    assign RECHARGE_FLAG = recharge_request_flag;
    assign INPUT_LIMIT = limit;
    assign SECONDARY_DETECT_EN = secondary_detect_enable;
    assign PRIMARY_DETECT_EN = primary_detect_enable;
endmodule
`default_nettype wire

// >>> shared/cimb_pkg.sv
// package: register map, field layout, states and carriers of the charger interrupt mask bank
package cimb_pkg;
    // register offsets
    localparam logic [7:0] SYS_FAULT_MASK_ADDR = 8'h0B;
    localparam logic [7:0] CHARGER_FAULT_MASK_ADDR = 8'h0C;
    localparam logic [7:0] BOOST_FAULT_MASK_ADDR = 8'h0D;
    localparam logic [7:0] DETECT_CONTROL_ADDR = 8'h0E;
    // reset values
    localparam logic [7:0] SYS_FAULT_MASK_RESET = 8'h00;
    localparam logic [7:0] CHARGER_FAULT_MASK_RESET = 8'h00;
    localparam logic [7:0] BOOST_FAULT_MASK_RESET = 8'h00;
    localparam logic [7:0] DETECT_CONTROL_RESET = 8'h16;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // field layout
    localparam int MISSING_BATTERY_BIT = 0;
    localparam int INPUT_REVERSE_BIT = 7;
    localparam int RECHARGE_REQUEST_BIT = 3;
    localparam int THERMAL_LOOP_BIT = 1;
    localparam int BOOST_OVERLOAD_BIT = 6;
    localparam int BOOST_LOW_BATTERY_BIT = 5;
    localparam logic [7:0] BOOST_MASK_USED = 8'hE0;
    localparam logic [7:0] DETECT_CONTROL_WRITABLE = 8'h1E;
    localparam int KIND_LSB = 5;
    localparam int SEL_LSB = 3;
    localparam int SECONDARY_BIT = 2;
    localparam int PRIMARY_BIT = 1;
    // input limit source select
    localparam logic [1:0] LIMIT_FROM_KIND = 2'h0;
    localparam logic [1:0] LIMIT_FROM_AVERAGE = 2'h1;
    localparam logic [1:0] LIMIT_HIGHER = 2'h2;
    localparam logic [1:0] LIMIT_LOWER = 2'h3;
    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h25; // arbitrary value
    // serial slave states
    typedef enum logic [8:0] {
        CIMB_IDLE = 9'h001,
        CIMB_ADDR = 9'h002,
        CIMB_ACK_ADDR = 9'h004,
        CIMB_REG = 9'h008,
        CIMB_ACK_REG = 9'h010,
        CIMB_WDATA = 9'h020,
        CIMB_ACK_W = 9'h040,
        CIMB_RDATA = 9'h080,
        CIMB_ACK_R = 9'h100
    } cimb_state_t;
    // fault flag bundle from the flag registers
    typedef struct packed {
        logic [7:0] sys;
        logic [7:0] chg;
        logic [7:0] bst;
    } cimb_flags_t;
    // battery voltage codes for the recharge comparison
    typedef struct packed {
        logic [9:0] bat;
        logic [9:0] reg_level;
        logic [9:0] recharge;
    } cimb_volt_t;
endpackage

// >>> tb/charger_interrupt_mask_bank_bench.sv
// self-checking bench for the charger interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
module charger_interrupt_mask_bank_bench;
    logic clk, rst, scl, host_low, sda, sda_out, sda_oe_n, rch_clr, running, irq_out, irq_oe_n, rflag, sec, pri, irq_n;
    cimb_pkg::cimb_flags_t flags;
    cimb_pkg::cimb_volt_t volts;
    logic [2:0] kind;
    logic [4:0] kind_lim, avg_lim, ilim;
    logic [7:0] lim_exp [8] = '{8'h0A, 8'h14, 8'h14, 8'h0A, 8'h14, 8'h0A, 8'h14, 8'h0A};
    int bad_count = 0;
    int num_checks = 0;
    // wired lines with pull-ups
    assign sda = !(host_low || (!sda_oe_n && !sda_out));
    assign irq_n = !(!irq_oe_n && !irq_out);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    cimb_top u_dut (.CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .FLAGS(flags), .VOLTS(volts), .RECHARGE_CLEAR(rch_clr), .DETECTED_KIND(kind), .DETECTION_RUNNING(running),
        .KIND_LIMIT(kind_lim), .AVERAGE_LIMIT(avg_lim), .IRQ_OUT(irq_out), .IRQ_OE_N(irq_oe_n),
        .RECHARGE_FLAG(rflag), .INPUT_LIMIT(ilim), .SECONDARY_DETECT_EN(sec), .PRIMARY_DETECT_EN(pri));
    cimb_host #(.SLAVE_ADDR(cimb_pkg::DEFAULT_SLAVE_ADDR)) u_host (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(host_low));
    // compare and count
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus accesses, acknowledge checked with the data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_host.write_reg(a, d, ok);
        check({8'h00, ok}, 9'h001);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_host.read_reg(a, d, ok);
        check({ok, d}, {1'b1, exp});
    endtask
    // bursts over two consecutive registers, pointer auto increment
    task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        logic ok;
        u_host.write_pair(a, d0, d1, ok);
        check({8'h00, ok}, 9'h001);
    endtask
    task automatic rd2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic ok;
        logic [7:0] d0, d1;
        u_host.read_pair(a, d0, d1, ok);
        check({ok, d0}, {1'b1, e0});
        check({1'b0, d1}, {1'b0, e1});
    endtask
    // event reaches the line until its own mask bit is set, other bits leave it
    task automatic mask_case(input cimb_pkg::cimb_flags_t f, input logic [7:0] a, input logic [7:0] m);
        @(posedge clk);
        flags <= f;
        repeat (3) @(posedge clk);
        check({8'h00, irq_n}, 9'h000);
        wr(a, ~m);
        check({8'h00, irq_n}, 9'h000);
        wr(a, m);
        check({8'h00, irq_n}, 9'h001);
        wr(a, 8'h00);
        flags <= '0;
    endtask
    // verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        flags = '0;
        volts = {10'h3F0, 10'h300, 10'h020};
        rch_clr = 1'b0;
        kind = 3'h5;
        running = 1'b1;
        kind_lim = 5'h0A;
        avg_lim = 5'h14;
        repeat (12) @(posedge clk);
        check({6'h00, sec, pri, irq_n}, 9'h007);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({4'h0, ilim}, 9'h014);
        rd(8'h0C, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'hB7);
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            kind_lim <= (s < 4) ? 5'h0A : 5'h14;
            avg_lim <= (s < 4) ? 5'h14 : 5'h0A;
            wr(8'h0E, {3'h0, s[1:0], 3'h6});
            check({4'h0, ilim}, {1'b0, lim_exp[s]});
        end
        running <= 1'b0;
        wr(8'h0E, 8'hFF);
        rd(8'h0E, 8'hBE);
        wr(8'h0E, 8'h00);
        check({7'h00, sec, pri}, 9'h000);
        mask_case({8'h01, 8'h00, 8'h00}, 8'h0B, 8'h01);
        mask_case({8'h00, 8'h80, 8'h00}, 8'h0C, 8'h80);
        mask_case({8'h00, 8'h02, 8'h00}, 8'h0C, 8'h02);
        mask_case({8'h00, 8'h00, 8'h40}, 8'h0D, 8'h40);
        mask_case({8'h00, 8'h00, 8'h20}, 8'h0D, 8'h20);
        @(posedge clk);
        flags <= {8'h00, 8'h08, 8'h1F};
        repeat (3) @(posedge clk);
        check({8'h00, irq_n}, 9'h001);
        wr(8'h0D, 8'hFF);
        rd(8'h0D, 8'hE0);
        wr2(8'h0C, 8'h5A, 8'h00);
        rd2(8'h0C, 8'h5A, 8'h00);
        wr(8'h0C, 8'h00);
        flags <= '0;
        volts.bat <= 10'h100;
        repeat (3) @(posedge clk);
        check({7'h00, rflag, irq_n}, 9'h002);
        wr(8'h0C, 8'h08);
        check({7'h00, rflag, irq_n}, 9'h003);
        volts.bat <= 10'h3F0;
        rch_clr <= 1'b1;
        repeat (2) @(posedge clk);
        rch_clr <= 1'b0;
        @(posedge clk);
        check({8'h00, rflag}, 9'h000);
        wr(8'h0C, 8'h00);
        wr(8'h30, 8'h5A);
        rd(8'h30, 8'h00);
        end_sim();
    end
    // watchdog against a hung bus
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule
bind cimb_top cimb_props u_props (.CLK(CLK), .RST(RST), .SDA_OUT(SDA_OUT), .FLAGS(FLAGS), .VOLTS(VOLTS),
    .RECHARGE_CLEAR(RECHARGE_CLEAR), .KIND_LIMIT(KIND_LIMIT), .AVERAGE_LIMIT(AVERAGE_LIMIT), .IRQ_OUT(IRQ_OUT),
    .IRQ_OE_N(IRQ_OE_N), .RECHARGE_FLAG(RECHARGE_FLAG), .INPUT_LIMIT(INPUT_LIMIT));
`default_nettype wire

// >>> tb/cimb_host.sv
// host model: serial register bus master with open-drain data line
`timescale 1ns/1ps
`default_nettype none
module cimb_host #(
    parameter logic [6:0] SLAVE_ADDR = 7'h25
) (
    // clock
    input wire logic clk,
    // bus wires
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam int Q = 6;
    // bus idle: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // a quarter of a bit period, long against the pin synchroniser
    task automatic quarter();
        repeat (Q) @(posedge clk);
    endtask
    // drive one bit, sample the wire mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        quarter();
        scl <= 1'b1;
        quarter();
        s = sda;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask
    // start or repeated start
    task automatic start();
        sda_low <= 1'b0;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_low <= 1'b1;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask
    // stop, then bus idle
    task automatic stop();
        sda_low <= 1'b1;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_low <= 1'b0;
        quarter();
    endtask
    // one byte plus acknowledge bit; all ones releases the line to receive
    task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            r[i] = s;
        end
        bit_io(last, s);
        ack = !s;
    endtask
    // register write: address, pointer, data
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        xfer(d, 1'b1, r, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // register read: pointer write, repeated start, one byte ended by no acknowledge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        start();
        xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, k2);
        xfer(8'hFF, 1'b1, d, k3);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // burst write: pointer then two data bytes into consecutive registers
    task automatic write_pair(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        xfer(d0, 1'b1, r, k2);
        xfer(d1, 1'b1, r, k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask
    // burst read: first byte acknowledged by the host, second ended by no acknowledge
    task automatic read_pair(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3, k4;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        start();
        xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, k2);
        xfer(8'hFF, 1'b0, d0, k3);
        xfer(8'hFF, 1'b1, d1, k4);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule
`default_nettype wire

// >>> tb/cimb_props.sv
// assertion checker for the charger interrupt mask bank ports
`timescale 1ns/1ps
`default_nettype none
module cimb_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // watched ports
    input wire logic SDA_OUT,
    input wire cimb_pkg::cimb_flags_t FLAGS,
    input wire cimb_pkg::cimb_volt_t VOLTS,
    input wire logic RECHARGE_CLEAR,
    input wire logic [4:0] KIND_LIMIT,
    input wire logic [4:0] AVERAGE_LIMIT,
    input wire logic IRQ_OUT,
    input wire logic IRQ_OE_N,
    input wire logic RECHARGE_FLAG,
    input wire logic [4:0] INPUT_LIMIT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic low_bat;
    logic quiet;
    // battery under the recharge level, an underflowing level never counts
    assign low_bat = VOLTS.reg_level >= VOLTS.recharge && VOLTS.bat < VOLTS.reg_level - VOLTS.recharge;
    // no source that can reach the line; reserved bits and flag bit 3 left out
    assign quiet = FLAGS.sys == 8'h00 && (FLAGS.chg & 8'hF7) == 8'h00 && FLAGS.bst[7:5] == 3'h0;
    irq_idle_a: assert property ((quiet && !RECHARGE_FLAG) ##1 !RECHARGE_FLAG |-> IRQ_OE_N)
        else $error("interrupt asserted with no source");
    reserved_quiet_a: assert property ((quiet && FLAGS.bst[4:0] != 5'h00 && !RECHARGE_FLAG)
        ##1 !RECHARGE_FLAG |-> IRQ_OE_N)
        else $error("reserved boost bit raised the interrupt");
    irq_pin_a: assert property (IRQ_OUT == 1'b0)
        else $error("interrupt pin driven high");
    sda_pin_a: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    recharge_set_a: assert property (low_bat |=> RECHARGE_FLAG)
        else $error("recharge flag not set for low battery");
    recharge_hold_a: assert property (RECHARGE_FLAG && !RECHARGE_CLEAR |=> RECHARGE_FLAG)
        else $error("recharge flag dropped without clear");
    recharge_clear_a: assert property (RECHARGE_CLEAR && !low_bat |=> !RECHARGE_FLAG)
        else $error("recharge flag survived clear");
    // started only out of reset: the limit register still holds its reset value one edge after release
    limit_pick_a: assert property (!RST |=> INPUT_LIMIT == $past(KIND_LIMIT)
        || INPUT_LIMIT == $past(AVERAGE_LIMIT))
        else $error("input limit from neither source");
endmodule
`default_nettype wire
